//--- pkg/bcec_cfg.svh
`ifndef BCEC_CFG_SVH
`define BCEC_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define BCEC_OFS_CTRL     12'h000
`define BCEC_OFS_STATUS   12'h004
`define BCEC_OFS_IRQ_STAT 12'h008
`define BCEC_OFS_IRQ_MASK 12'h00c
`define BCEC_OFS_BCYCLES  12'h010
`define BCEC_OFS_LASTLEN  12'h014
`define BCEC_OFS_TSTAMP   12'h018
`define BCEC_OFS_EOBTS    12'h01c

// ----------------------------------------------------------------
// control bits
// ----------------------------------------------------------------
`define BCEC_CTRL_CHOKE_REQ 0
`define BCEC_CTRL_ERROR_REQ 1
`define BCEC_CTRL_W         2

// ----------------------------------------------------------------
// status bits
// ----------------------------------------------------------------
`define BCEC_ST_IN_BURST 0
`define BCEC_ST_CHOKE    1
`define BCEC_ST_ERROR    2
`define BCEC_ST_CHK_ACK  3
`define BCEC_ST_ERR_ACK  4
`define BCEC_ST_SEQ_ERR  5

// ----------------------------------------------------------------
// interrupt event bits
// ----------------------------------------------------------------
`define BCEC_EV_SOB     0
`define BCEC_EV_EOB     1
`define BCEC_EV_SEQ     2
`define BCEC_EV_CHOKE   3
`define BCEC_EV_ERROR   4
`define BCEC_EV_RSVD    5
`define BCEC_EV_W       6

// ----------------------------------------------------------------
// command and trigger type codes
// ----------------------------------------------------------------
`define BCEC_CMD_SOB     2'b11
`define BCEC_CMD_EOB     2'b01
`define BCEC_TT_SOB      6'h22
`define BCEC_TT_EOB      6'h23
`define BCEC_TT_CHK_ON   6'h24
`define BCEC_TT_CHK_OFF  6'h25
`define BCEC_TT_ERR_ON   6'h26
`define BCEC_TT_ERR_OFF  6'h2f

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BCEC_RST_MASK 6'h00

`endif

//--- pkg/bcec_pkg.sv
package bcec_pkg;

	// broadcast message from the timing link, already sampled
	typedef struct packed {
		logic       valid;
		logic [7:0] word;
	} bcec_bcast_s;

	// trigger pulse with its type code
	typedef struct packed {
		logic       valid;
		logic [5:0] ttype;
	} bcec_trig_s;

	typedef enum logic [2:0] {
		BCEC_IDLE  = 3'b001,
		BCEC_BURST = 3'b010,
		BCEC_LOST  = 3'b100
	} bcec_burst_e;

	typedef enum logic [2:0] {
		BCEC_OFF  = 3'b001,
		BCEC_WAIT = 3'b010,
		BCEC_ACKD = 3'b100
	} bcec_line_e;

endpackage

//--- rtl/bcec_ctrl.sv
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`include "bcec_cfg.svh"
// Notes on behaviour
// [R1] bits 11 mean start-of-burst, 01 end-of-burst, 10 reserved
// [R2] the two burst flags sit in the two lowest command word bits
// [R3] trigger processor sends start-of-burst on early warning, before data-taking
// [R4] trigger processor sends end-of-burst on delayed extraction end
// [R5] start and end must alternate and always be sent
// [R6] out-of-order burst command marks burst lost and flags serious error
// [R7] count clock cycles between start-of-burst and end-of-burst
// [R8] burst timing uses only start/end commands, no other timing input
// [R9] choke and error outputs report faults, not routine flow control
// [R10] choke rises when overloaded and near losing triggers
// [R11] trigger processor stops triggers within about one microsecond
// [R12] delivered triggers still processed while choke is high
// [R13] error rises on unserviceable request, stale timestamp, any loss
// [R14] choke/error held at least until matching on-acknowledge trigger
// [R15] trigger processor may mask any source's choke and error lines
// [R16] six-bit trigger type; choke/error on/off codes request special frames
// [R17] start type enables data-taking, end type disables and asks readout
// [R18] start-of-burst synchronously clears local timestamp counter
// [R19] after acknowledge, line drops only once its cause has gone
module bcec_ctrl
	import bcec_pkg::*;
(
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// timing link, asynchronous to pclk
	input  wire logic        link_clk,
	input  wire logic        bcast_strobe,
	input  wire logic [7:0]  bcast_word,
	input  wire logic        trig_pulse,
	input  wire logic [5:0]  trig_type,
	// local fault causes, same domain
	input  wire logic        overload,
	input  wire logic        trig_unserviceable,
	input  wire logic        trig_stale,
	// outputs to trigger processor and readout, and the interrupt
	output logic             choke,
	output logic             error,
	output logic             data_taking,
	output logic             special_frame,
	output logic             eob_readout,
	output logic             irq
);

	// ----------------------------------------------------------------
	// link input synchronisers
	// ----------------------------------------------------------------
	logic [16:0] sync1;
	logic [16:0] sync2;
	logic        lclk_d;
	bcec_bcast_s bcast;
	bcec_trig_s  trig;

	// two flops per input; strobes sampled after link edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 17'h00000;
			sync2 <= 17'h00000;
		end else begin
			sync1 <= {link_clk, bcast_strobe, bcast_word, trig_pulse, trig_type};
			sync2 <= sync1;
		end
	end

	// rising edge of link clock found in pclk domain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lclk_d <= 1'b0;
		end else begin
			lclk_d <= sync2[16];
		end
	end

	logic lclk_rise;
	assign lclk_rise   = sync2[16] & ~lclk_d;
	// data is stable across the edge since it launches on the far edge
	assign bcast.valid = lclk_rise & sync2[15];
	assign bcast.word  = sync2[14:7];
	assign trig.valid  = lclk_rise & sync2[6];
	assign trig.ttype  = sync2[5:0];

	// ----------------------------------------------------------------
	// burst command decode
	// ----------------------------------------------------------------
	logic [1:0] cmd;
	logic       cmd_sob;
	logic       cmd_eob;
	logic       cmd_rsvd;
	// bunch_count_clear_bit is bit 0, event_count_clear_bit bit 1
	assign cmd      = {bcast.word[1], bcast.word[0]}; // [R2]
	assign cmd_sob  = bcast.valid & (cmd == `BCEC_CMD_SOB); // [R1]
	assign cmd_eob  = bcast.valid & (cmd == `BCEC_CMD_EOB); // [R1]
	assign cmd_rsvd = bcast.valid & (cmd == 2'b10); // [R1]

	// ----------------------------------------------------------------
	// burst sequencer
	// ----------------------------------------------------------------
	bcec_burst_e burst;
	logic        seq_err_ev;
	// only the commands drive burst state, no other timing input [R8]
	assign seq_err_ev = (cmd_sob & (burst != BCEC_IDLE))
		| (cmd_eob & (burst == BCEC_IDLE)); // [R6]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			burst <= BCEC_IDLE;
		end else begin
			case (burst)
			BCEC_IDLE: begin
				if (cmd_sob) begin
					burst <= BCEC_BURST;
				end
			end
			BCEC_BURST: begin
				if (cmd_sob) begin
					burst <= BCEC_LOST; // [R6]
				end else if (cmd_eob) begin
					burst <= BCEC_IDLE;
				end
			end
			BCEC_LOST: begin
				if (cmd_eob) begin
					burst <= BCEC_IDLE;
				end
			end
			default: begin
				burst <= BCEC_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// cycle counting and timestamp
	// ----------------------------------------------------------------
	logic [31:0] burst_cycles;
	logic [31:0] last_len;
	logic [31:0] tstamp;
	logic [31:0] eob_tstamp;

	// counts link clock cycles inside the burst [R7]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			burst_cycles <= 32'h00000000;
			last_len     <= 32'h00000000;
		end else if (cmd_sob) begin
			burst_cycles <= 32'h00000000; // [R7]
		end else if (cmd_eob && burst != BCEC_IDLE) begin
			last_len <= burst_cycles; // [R7]
		end else if (lclk_rise && burst != BCEC_IDLE) begin
			burst_cycles <= burst_cycles + 32'h00000001; // [R7]
		end
	end

	// free-running stamp, cleared by start-of-burst
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tstamp     <= 32'h00000000;
			eob_tstamp <= 32'h00000000;
		end else begin
			if (cmd_sob) begin
				tstamp <= 32'h00000000; // [R18]
			end else if (lclk_rise) begin
				tstamp <= tstamp + 32'h00000001;
			end
			if (cmd_eob) begin
				eob_tstamp <= tstamp;
			end
		end
	end

	// ----------------------------------------------------------------
	// trigger type actions
	// ----------------------------------------------------------------
	logic ack_choke;
	logic ack_error;
	assign ack_choke = trig.valid & (trig.ttype == `BCEC_TT_CHK_ON); // [R16]
	assign ack_error = trig.valid & (trig.ttype == `BCEC_TT_ERR_ON); // [R16]

	// data-taking gate and one-cycle readout requests
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_taking   <= 1'b0;
			special_frame <= 1'b0;
			eob_readout   <= 1'b0;
		end else begin
			special_frame <= trig.valid & (trig.ttype == `BCEC_TT_SOB
				|| trig.ttype == `BCEC_TT_CHK_ON || trig.ttype == `BCEC_TT_CHK_OFF
				|| trig.ttype == `BCEC_TT_ERR_ON || trig.ttype == `BCEC_TT_ERR_OFF); // [R16]
			eob_readout   <= trig.valid & (trig.ttype == `BCEC_TT_EOB); // [R17]
			if (trig.valid && trig.ttype == `BCEC_TT_SOB) begin
				data_taking <= 1'b1; // [R17]
			end else if (trig.valid && trig.ttype == `BCEC_TT_EOB) begin
				data_taking <= 1'b0; // [R17]
			end
		end
	end

	// ----------------------------------------------------------------
	// choke and error lines
	// ----------------------------------------------------------------
	logic [`BCEC_CTRL_W-1:0] ctrl;
	logic                    choke_cause;
	logic                    error_cause;
	logic                    seq_err;
	bcec_line_e              chk_st;
	bcec_line_e              err_st;

	// triggers keep flowing to readout regardless of choke [R12]
	assign choke_cause = overload | ctrl[`BCEC_CTRL_CHOKE_REQ]; // [R10]
	assign error_cause = trig_unserviceable | trig_stale | seq_err
		| ctrl[`BCEC_CTRL_ERROR_REQ]; // [R13]

	// sequence error latched until next clean start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_err <= 1'b0;
		end else if (seq_err_ev) begin
			seq_err <= 1'b1; // [R6]
		end else if (cmd_sob) begin
			seq_err <= 1'b0;
		end
	end

	// choke held until ack, then until cause gone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chk_st <= BCEC_OFF;
		end else begin
			case (chk_st)
			BCEC_OFF:  if (choke_cause) chk_st <= BCEC_WAIT; // [R10]
			BCEC_WAIT: if (ack_choke) chk_st <= BCEC_ACKD; // [R14]
			BCEC_ACKD: if (!choke_cause) chk_st <= BCEC_OFF; // [R19]
			default:   chk_st <= BCEC_OFF;
			endcase
		end
	end

	// error line, same discipline
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_st <= BCEC_OFF;
		end else begin
			case (err_st)
			BCEC_OFF:  if (error_cause) err_st <= BCEC_WAIT; // [R13]
			BCEC_WAIT: if (ack_error) err_st <= BCEC_ACKD; // [R14]
			BCEC_ACKD: if (!error_cause) err_st <= BCEC_OFF; // [R19]
			default:   err_st <= BCEC_OFF;
			endcase
		end
	end

	// fault lines only, never a flow-control handshake [R9]
	assign choke = (chk_st != BCEC_OFF); // [R9]
	assign error = (err_st != BCEC_OFF); // [R9]

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	logic [`BCEC_EV_W-1:0] irq_stat;
	logic [`BCEC_EV_W-1:0] irq_mask;
	logic [`BCEC_EV_W-1:0] ev;
	logic                  rd_stat;
	logic                  acc;

	assign acc     = psel & penable;
	assign rd_stat = acc & ~pwrite & (paddr == `BCEC_OFS_IRQ_STAT);
	// entry into a held line is the event, so a read can clear it while held
	assign ev      = {cmd_rsvd, (err_st == BCEC_OFF) & error_cause,
		(chk_st == BCEC_OFF) & choke_cause, seq_err_ev, cmd_eob, cmd_sob};

	// read clears only what the setup cycle reported; new events still set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= 6'h00;
		end else begin
			irq_stat <= (rd_stat ? (irq_stat & ~prdata[5:0]) : irq_stat) | ev;
		end
	end

	assign irq = |(irq_stat & irq_mask);

	// ----------------------------------------------------------------
	// apb registers
	// ----------------------------------------------------------------
	// zero wait states keep the slave trivially timed
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl     <= 2'b00;
			irq_mask <= `BCEC_RST_MASK;
		end else if (acc && pwrite) begin
			if (paddr == `BCEC_OFS_CTRL) ctrl <= pwdata[1:0];
			if (paddr == `BCEC_OFS_IRQ_MASK) irq_mask <= pwdata[5:0];
		end
	end

	// read data registered at setup so it is ready in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
			`BCEC_OFS_CTRL:     prdata <= {30'h0, ctrl};
			`BCEC_OFS_STATUS:   prdata <= {26'h0, seq_err, err_st == BCEC_ACKD,
				chk_st == BCEC_ACKD, error, choke, burst == BCEC_BURST};
			`BCEC_OFS_IRQ_STAT: prdata <= {26'h0, irq_stat};
			`BCEC_OFS_IRQ_MASK: prdata <= {26'h0, irq_mask};
			`BCEC_OFS_BCYCLES:  prdata <= burst_cycles;
			`BCEC_OFS_LASTLEN:  prdata <= last_len;
			`BCEC_OFS_TSTAMP:   prdata <= tstamp;
			`BCEC_OFS_EOBTS:    prdata <= eob_tstamp;
			default:            prdata <= 32'h00000000;
			endcase
		end
	end

endmodule

//--- testbench/bcec_tp_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// trigger processor seen from the device: timing link out, choke and error lines back
// ----------------------------------------------------------------
module bcec_tp_model
	import bcec_pkg::*;
(
	// link toward the device
	output logic       link_clk,
	output logic       bcast_strobe,
	output logic [7:0] bcast_word,
	output logic       trig_pulse,
	output logic [5:0] trig_type,
	// fault lines back from the device, and their mask
	input  wire logic  choke,
	input  wire logic  error,
	input  wire logic  fault_mask
);
	// distributed clock runs free, also between bursts
	initial begin
		link_clk = 1'b0;
		forever #40 link_clk = ~link_clk;
	end
	initial begin
		bcast_strobe = 1'b0;
		bcast_word = 8'h00;
		trig_pulse = 1'b0;
		trig_type = 6'h00;
	end
	// burst flags in the two low bits, held across one rise, then scrambled
	task automatic send_cmd(input logic [1:0] cmd);
		@(negedge link_clk);
		bcast_word <= {6'h00, cmd};
		bcast_strobe <= 1'b1;
		@(negedge link_clk);
		bcast_strobe <= 1'b0;
		bcast_word <= ~{6'h00, cmd};
	endtask
	// physics triggers held back on an unmasked fault, special ones still go
	task automatic send_trig(input logic [5:0] tt);
		@(negedge link_clk);
		if (!(tt[5] == 1'b0 && (choke | error) && !fault_mask)) begin
			trig_type <= tt;
			trig_pulse <= 1'b1;
		end
		@(negedge link_clk);
		trig_pulse <= 1'b0;
		trig_type <= ~tt;
	endtask
endmodule

//--- testbench/bcec_ctrl_monitor.sv
`timescale 1ns/1ps
module bcec_ctrl_monitor (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// fault causes
	input wire logic overload,
	input wire logic trig_unserviceable,
	input wire logic trig_stale,
	// observed outputs
	input wire logic choke,
	input wire logic error,
	input wire logic special_frame,
	input wire logic eob_readout
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// the acknowledge needs a link round trip, so a line cannot vanish sooner
	sequence s_choke_held; choke [*4]; endsequence
	sequence s_error_held; error [*4]; endsequence
	chk_choke_rise: assert property ($rose(overload) |-> ##[1:3] choke)
		else $error("choke did not follow overload");
	chk_error_unsrv: assert property ($rose(trig_unserviceable) |-> ##[1:3] error)
		else $error("error did not follow unserviceable request");
	chk_error_stale: assert property ($rose(trig_stale) |-> ##[1:3] error)
		else $error("error did not follow stale timestamp");
	chk_choke_held: assert property ($rose(choke) |-> s_choke_held)
		else $error("choke dropped too early");
	chk_error_held: assert property ($rose(error) |-> s_error_held)
		else $error("error dropped too early");
	chk_choke_drop: assert property ($fell(choke) |-> !$past(overload))
		else $error("choke dropped with overload present");
	chk_error_drop: assert property ($fell(error) |-> !$past(trig_unserviceable)
		&& !$past(trig_stale))
		else $error("error dropped with cause present");
	chk_frame_pulse: assert property (special_frame |=> !special_frame)
		else $error("special frame longer than one cycle");
	chk_eob_pulse: assert property (eob_readout |=> !eob_readout)
		else $error("end readout longer than one cycle");
endmodule

bind bcec_ctrl bcec_ctrl_monitor mon (.pclk(pclk), .presetn(presetn), .overload(overload),
	.trig_unserviceable(trig_unserviceable), .trig_stale(trig_stale), .choke(choke),
	.error(error), .special_frame(special_frame), .eob_readout(eob_readout));

//--- testbench/burst_choke_error_control_bench.sv
`timescale 1ns/1ps
`include "bcec_cfg.svh"
module burst_choke_error_control_bench
	import bcec_pkg::*;
;
	typedef struct packed {logic [5:0] t; logic sf; logic eo; logic dt;} bcec_row_s;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, link_clk;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        bcast_strobe, trig_pulse, overload, trig_unserviceable, trig_stale;
	logic [7:0]  bcast_word;
	logic [5:0]  trig_type;
	logic        choke, error, data_taking, special_frame, eob_readout, irq;
	int          err_count = 0;
	int          compares = 0;
	bcec_row_s   rows [7] = '{'{`BCEC_TT_SOB, 1'b1, 1'b0, 1'b1}, '{6'h05, 1'b0, 1'b0, 1'b1},
		'{`BCEC_TT_CHK_ON, 1'b1, 1'b0, 1'b1}, '{`BCEC_TT_CHK_OFF, 1'b1, 1'b0, 1'b1},
		'{`BCEC_TT_ERR_ON, 1'b1, 1'b0, 1'b1}, '{`BCEC_TT_ERR_OFF, 1'b1, 1'b0, 1'b1},
		'{`BCEC_TT_EOB, 1'b0, 1'b1, 1'b0}};
	bcec_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link_clk(link_clk), .bcast_strobe(bcast_strobe),
		.bcast_word(bcast_word), .trig_pulse(trig_pulse), .trig_type(trig_type),
		.overload(overload), .trig_unserviceable(trig_unserviceable), .trig_stale(trig_stale),
		.choke(choke), .error(error), .data_taking(data_taking),
		.special_frame(special_frame), .eob_readout(eob_readout), .irq(irq));
	bcec_tp_model tp (.link_clk(link_clk), .bcast_strobe(bcast_strobe),
		.bcast_word(bcast_word), .trig_pulse(trig_pulse), .trig_type(trig_type),
		.choke(choke), .error(error), .fault_mask(1'b0));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic pick(input int k);
		return (k == 0) ? choke : (k == 1) ? error : irq;
	endfunction
	// setup, access until pready, release, one idle edge so no double drive
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20) begin
			err_count++;
			end_sim();
		end
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic watch(input int lim, output logic [31:0] sf, output logic [31:0] eo);
		sf = 0;
		eo = 0;
		repeat (lim) begin
			@(negedge pclk);
			sf += special_frame;
			eo += eob_readout;
		end
	endtask
	task automatic chk_line(input int k, input logic v);
		@(negedge pclk);
		check({31'h0, pick(k)}, {31'h0, v});
		@(posedge pclk);
	endtask
	task automatic wait_for(input int k, input logic v, input int lim);
		int n;
		n = 0;
		while (pick(k) !== v && n < lim) begin
			@(negedge pclk);
			n++;
		end
		check({31'h0, pick(k)}, {31'h0, v});
		if (n >= lim) end_sim();
		@(posedge pclk);
	endtask
	task automatic set_cause(input int k, input logic v);
		case (k)
			0: overload <= v;
			1: trig_unserviceable <= v;
			default: trig_stale <= v;
		endcase
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] q, nsf, neo;
		presetn = 1'b0;
		{psel, penable, pwrite, overload, trig_unserviceable, trig_stale} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (40) @(posedge pclk);
		apb(1'b0, `BCEC_OFS_STATUS, 32'h0, q);
		check(q, 32'h0);
		apb(1'b0, `BCEC_OFS_IRQ_MASK, 32'h0, q);
		check(q, {26'h0, `BCEC_RST_MASK});
		apb(1'b0, 12'h100, 32'h0, q);
		check(q, 32'h0);
		foreach (rows[i]) begin
			fork
				tp.send_trig(rows[i].t);
				watch(30, nsf, neo);
			join
			check(nsf, {31'h0, rows[i].sf});
			check(neo, {31'h0, rows[i].eo});
			check({31'h0, data_taking}, {31'h0, rows[i].dt});
			@(posedge pclk);
		end
		// burst length, stickies cleared by the read
		apb(1'b1, `BCEC_OFS_IRQ_MASK, 32'h3f, q);
		apb(1'b0, `BCEC_OFS_IRQ_STAT, 32'h0, q);
		tp.send_cmd(`BCEC_CMD_SOB);
		repeat (5) @(posedge link_clk);
		tp.send_cmd(`BCEC_CMD_EOB);
		repeat (10) @(posedge pclk);
		chk_line(2, 1'b1);
		apb(1'b0, `BCEC_OFS_LASTLEN, 32'h0, q);
		check(q, 32'd5);
		// stamp was cleared by the start, five rises before the end
		apb(1'b0, `BCEC_OFS_EOBTS, 32'h0, q);
		check(q, 32'd5);
		apb(1'b0, `BCEC_OFS_IRQ_STAT, 32'h0, q);
		check(q, 32'h3);
		chk_line(2, 1'b0);
		// reserved code, masked: sticky only, no interrupt
		apb(1'b1, `BCEC_OFS_IRQ_MASK, 32'h0, q);
		tp.send_cmd(2'b10);
		repeat (10) @(posedge pclk);
		chk_line(2, 1'b0);
		apb(1'b0, `BCEC_OFS_IRQ_STAT, 32'h0, q);
		check(q, 32'h20);
		// start inside a burst loses it
		tp.send_cmd(`BCEC_CMD_SOB);
		tp.send_cmd(`BCEC_CMD_SOB);
		repeat (10) @(posedge pclk);
		chk_line(1, 1'b1);
		apb(1'b0, `BCEC_OFS_STATUS, 32'h0, q);
		check({31'h0, q[`BCEC_ST_SEQ_ERR]}, 32'h1);
		// lost burst must end before a clean start clears the sequence error
		tp.send_cmd(`BCEC_CMD_EOB);
		tp.send_cmd(`BCEC_CMD_SOB);
		tp.send_trig(`BCEC_TT_ERR_ON);
		@(posedge pclk);
		wait_for(1, 1'b0, 40);
		tp.send_cmd(`BCEC_CMD_EOB);
		@(posedge pclk);
		// each input cause (overload, unserviceable, stale): held past its end, kept after ack while present
		for (int k = 0; k < 3; k++) begin
			set_cause(k, 1'b1);
			wait_for((k == 0) ? 0 : 1, 1'b1, 10);
			set_cause(k, 1'b0);
			repeat (30) @(posedge pclk);
			chk_line((k == 0) ? 0 : 1, 1'b1);
			set_cause(k, 1'b1);
			fork
				tp.send_trig((k == 0) ? `BCEC_TT_CHK_ON : `BCEC_TT_ERR_ON);
				watch(30, nsf, neo);
			join
			check(nsf, 32'h1);
			@(posedge pclk);
			chk_line((k == 0) ? 0 : 1, 1'b1);
			apb(1'b0, `BCEC_OFS_STATUS, 32'h0, q);
			check({31'h0, q[(k == 0) ? `BCEC_ST_CHK_ACK : `BCEC_ST_ERR_ACK]}, 32'h1);
			set_cause(k, 1'b0);
			wait_for((k == 0) ? 0 : 1, 1'b0, 10);
		end
		// software-forced choke follows the same hold discipline
		apb(1'b1, `BCEC_OFS_CTRL, 32'h1, q);
		wait_for(0, 1'b1, 10);
		tp.send_trig(`BCEC_TT_CHK_ON);
		@(posedge pclk);
		chk_line(0, 1'b1);
		apb(1'b1, `BCEC_OFS_CTRL, 32'h0, q);
		wait_for(0, 1'b0, 40);
		// mid-run reset drops a held choke at once
		set_cause(0, 1'b1);
		wait_for(0, 1'b1, 10);
		presetn <= 1'b0;
		set_cause(0, 1'b0);
		@(posedge pclk);
		chk_line(0, 1'b0);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		chk_line(0, 1'b0);
		apb(1'b0, `BCEC_OFS_STATUS, 32'h0, q);
		check(q, 32'h0);
		end_sim();
	end
endmodule
